// file: logic/ncs_defs.svh
// constants for the nand command sequencer host controller
`ifndef NCS_DEFS_SVH
`define NCS_DEFS_SVH
// flash command codes
`define NCS_CMD_READ        8'h00
`define NCS_CMD_READ_GO     8'h30
`define NCS_CMD_COPY_READ   8'h35
`define NCS_CMD_COPY_DEST   8'h85
`define NCS_CMD_PROG_GO     8'h10
`define NCS_CMD_ERASE_SETUP 8'h60
`define NCS_CMD_ERASE_GO    8'hD0
`define NCS_CMD_STATUS      8'h70
`define NCS_CMD_READ_ID     8'h90
`define NCS_CMD_RESET       8'hFF
`define NCS_ID_ADDR         8'h00
// status byte of the device
`define NCS_ST_FAIL         0
`define NCS_ST_PREV_FAIL    1
`define NCS_ST_TRUE_READY   5
`define NCS_ST_READY        6
`define NCS_ST_WP_OFF       7
`define NCS_ST_USED_MASK    8'hE3
`define NCS_ST_RESET_VAL    8'hC0
// controller registers (word index on the software port)
`define NCS_REG_CTRL        4'h0
`define NCS_REG_ADDR_LO     4'h1
`define NCS_REG_ADDR_HI     4'h2
`define NCS_REG_WDATA       4'h3
`define NCS_REG_STATUS      4'h4
`define NCS_REG_RDATA       4'h5
`define NCS_REG_FLASH_ST    4'h6
`define NCS_REG_ID          4'h7
// control register fields
`define NCS_CTRL_OP_LSB     0
`define NCS_CTRL_OP_W       4
`define NCS_CTRL_NDATA_LSB  8
`define NCS_CTRL_NDATA_W    8
// operation codes written to the control register
`define NCS_OP_COPY_READ    4'h1
`define NCS_OP_COPY_PROG    4'h2
`define NCS_OP_ERASE        4'h3
`define NCS_OP_STATUS       4'h4
`define NCS_OP_READ_ID      4'h5
`define NCS_OP_RESET        4'h6
`define NCS_OP_DATA_IN      4'h7
`define NCS_OP_READ_BYTE    4'h8
// timing
`define NCS_CLK_PERIOD_NS   8
`define NCS_POWER_WAIT_US   10
`define NCS_POWER_WAIT_CYC  ((`NCS_POWER_WAIT_US * 1000 + `NCS_CLK_PERIOD_NS - 1) / `NCS_CLK_PERIOD_NS)
`define NCS_STROBE_CYC      8
`define NCS_ADDR_CYC        5
`endif

// file: logic/ncs_pkg.sv
// types for the nand command sequencer host controller
package ncs_pkg;
  typedef enum logic [1:0] {
    NCS_CYC_CMD,
    NCS_CYC_ADDR,
    NCS_CYC_WDATA,
    NCS_CYC_RDATA
  } ncs_cyc_e;

  // one bus cycle request toward the pin driver
  typedef struct packed {
    ncs_cyc_e   kind;
    logic [7:0] data;
  } ncs_cyc_s;

  // flash pins driven by the controller
  typedef struct packed {
    logic chip_sel_n;
    logic cmd_latch;
    logic addr_latch;
    logic write_strobe_n;
    logic read_strobe_n;
    logic write_prot_n;
  } ncs_pins_s;
endpackage

// file: logic/ncs_bus_cycle.sv
// one flash bus cycle: command, address, write data or read data
`timescale 1ns/1ps
`include "ncs_defs.svh"
module ncs_bus_cycle
  import ncs_pkg::*;
(
  // clock and reset
  input  wire logic           clock_in,
  input  wire logic           rst_in,
  // request from the sequencer
  input  wire logic           start_in,
  input  wire ncs_pkg::ncs_cyc_s cyc_in,
  output logic                done_out,
  output logic [7:0]          rdata_out,
  // flash pins
  output logic                cle_out,
  output logic                ale_out,
  output logic                we_n_out,
  output logic                re_n_out,
  output logic [7:0]          io_out,
  output logic                io_oe_n_out,
  input  wire logic [7:0]     io_sync_in
);
  logic [3:0] cnt_q;
  logic       busy_q;
  ncs_cyc_s   cur_q;

  ////////////////////////////////////////////////////////////////////////////
  // write strobe low for the first half, high for the second; read strobe low for the whole cycle; data sampled at the end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      busy_q      <= 1'b0;
      cnt_q       <= 4'h0;
      cur_q       <= '0;
      done_out    <= 1'b0;
      rdata_out   <= 8'h00;
      cle_out     <= 1'b0;
      ale_out     <= 1'b0;
      we_n_out    <= 1'b1;
      re_n_out    <= 1'b1;
      io_out      <= 8'h00;
      io_oe_n_out <= 1'b1;
    end else begin
      done_out <= 1'b0;
      if (!busy_q && start_in) begin
        busy_q      <= 1'b1;
        cnt_q       <= 4'h0;
        cur_q       <= cyc_in;
        cle_out     <= (cyc_in.kind == NCS_CYC_CMD);
        ale_out     <= (cyc_in.kind == NCS_CYC_ADDR);
        io_out      <= cyc_in.data;
        io_oe_n_out <= (cyc_in.kind == NCS_CYC_RDATA);
        we_n_out    <= (cyc_in.kind == NCS_CYC_RDATA);
        re_n_out    <= (cyc_in.kind != NCS_CYC_RDATA);
      end else if (busy_q) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == 4'(`NCS_STROBE_CYC / 2 - 1)) begin
          // write strobe rises at the midpoint; the read strobe stays low until the last count
          we_n_out <= 1'b1;
        end
        if (cnt_q == 4'(`NCS_STROBE_CYC - 1)) begin
          if (cur_q.kind == NCS_CYC_RDATA) begin
            rdata_out <= io_sync_in;
          end
          re_n_out    <= 1'b1;
          cle_out     <= 1'b0;
          ale_out     <= 1'b0;
          io_oe_n_out <= 1'b1;
          busy_q      <= 1'b0;
          done_out    <= 1'b1;
        end
      end
    end
  end
endmodule

// file: logic/ncs_host.sv
// host controller that sequences commands to an asynchronous nand flash
// Functional notes
// - after ready, send 85h and destination
// - copy program starts only on 10h
// - erase is 60h plus two block addresses
// - reissue 00h before resuming reads (the read byte op sends no command; after 70h it returns the status byte)
// - mask unused status bits
// - 90h, 00h, four id bytes
// - wait recovery time after power up
`timescale 1ns/1ps
`include "ncs_defs.svh"
module ncs_host
  import ncs_pkg::*;
#(
  parameter int unsigned POWER_WAIT_CYC = `NCS_POWER_WAIT_CYC
)(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // software port
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out,
  // flash control pins
  output ncs_pkg::ncs_pins_s pins_out,
  // flash data pins, two-way
  output logic [7:0]       io_out,
  output logic             io_oe_n_out,
  input  wire logic [7:0]  io_in,
  // open-drain ready line from the flash
  input  wire logic        ready_in
);
  import ncs_pkg::*;

  typedef enum logic [3:0] {
    ST_POWER, ST_IDLE, ST_ISSUE, ST_WAIT_CYC, ST_WAIT_BUSY, ST_WAIT_READY, ST_DONE
  } ncs_state_e;

  function automatic logic is_prog_op(input logic [3:0] op);
    return (op == `NCS_OP_COPY_PROG) || (op == `NCS_OP_ERASE);
  endfunction

  ncs_state_e  state_q;
  logic [3:0]  op_q;
  logic [7:0]  ndata_q;
  logic [39:0] faddr_q;
  logic [7:0]  wbyte_q;
  logic        wp_off_q;
  logic [7:0]  rbyte_q;
  logic [7:0]  flash_st_q;
  logic [31:0] id_q;
  logic [3:0]  step_q;
  logic [13:0] power_q;
  logic        done_q;
  logic        fail_q;
  logic        op_busy_q;
  logic        dev_busy_q;
  logic [2:0]  rdy_sync_q;
  logic        rdy_q;
  logic [7:0]  io_s1_q;
  logic [7:0]  io_s2_q;
  logic [7:0]  io_s3_q;
  logic [7:0]  io_stable_q;
  ncs_cyc_s    cyc_d;
  logic        cyc_start_q;
  logic        cyc_last_d;
  ncs_cyc_s    cyc_q;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  logic        cle;
  logic        ale;
  logic        we_n;
  logic        re_n;

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdy_sync_q  <= 3'b000;
      rdy_q       <= 1'b0;
      io_s1_q     <= 8'h00;
      io_s2_q     <= 8'h00;
      io_s3_q     <= 8'h00;
      io_stable_q <= 8'h00;
    end else begin
      rdy_sync_q <= {rdy_sync_q[1:0], ready_in};
      if (rdy_sync_q[1] == rdy_sync_q[2]) begin
        rdy_q <= rdy_sync_q[2];
      end
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
      io_s3_q <= io_s2_q;
      if (io_s2_q == io_s3_q) begin
        io_stable_q <= io_s3_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ndata_q  <= 8'h00;
      faddr_q  <= 40'h0;
      wbyte_q  <= 8'h00;
      wp_off_q <= 1'b0;
    end else if (wr_in) begin
      case (addr_in)
        `NCS_REG_CTRL: begin
          ndata_q  <= wdata_in[`NCS_CTRL_NDATA_LSB +: `NCS_CTRL_NDATA_W];
          wp_off_q <= wdata_in[31];
        end
        `NCS_REG_ADDR_LO: faddr_q[31:0] <= wdata_in;
        `NCS_REG_ADDR_HI: faddr_q[39:32] <= wdata_in[7:0];
        `NCS_REG_WDATA: wbyte_q <= wdata_in[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0;
    end else if (rd_in) begin
      case (addr_in)
        `NCS_REG_CTRL: rdata_out <= {wp_off_q, 15'h0, ndata_q, 4'h0, op_q};
        `NCS_REG_ADDR_LO: rdata_out <= faddr_q[31:0];
        `NCS_REG_ADDR_HI: rdata_out <= {24'h0, faddr_q[39:32]};
        `NCS_REG_WDATA: rdata_out <= {24'h0, wbyte_q};
        `NCS_REG_STATUS: rdata_out <= {26'h0, rdy_q, dev_busy_q, fail_q, done_q,
                                       op_busy_q, (state_q == ST_POWER)};
        `NCS_REG_RDATA: rdata_out <= {24'h0, rbyte_q};
        // unused bits masked so software sees only defined flags
        `NCS_REG_FLASH_ST: rdata_out <= {24'h0, flash_st_q & `NCS_ST_USED_MASK};
        `NCS_REG_ID: rdata_out <= id_q;
        default: rdata_out <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle list of each operation; step indexes the list
  always_comb begin
    cyc_d      = '{kind: NCS_CYC_CMD, data: 8'h00};
    cyc_last_d = 1'b0;
    case (op_q)
      `NCS_OP_COPY_READ: begin
        if (step_q == 4'h0) cyc_d.data = `NCS_CMD_READ;
        else if (step_q <= 4'(`NCS_ADDR_CYC)) begin
          cyc_d.kind = NCS_CYC_ADDR;
          cyc_d.data = faddr_q[8*(step_q-4'h1) +: 8];
        end else begin
          cyc_d.data = `NCS_CMD_COPY_READ;
          cyc_last_d = 1'b1;
        end
      end
      `NCS_OP_COPY_PROG: begin
        if (step_q == 4'h0) cyc_d.data = `NCS_CMD_COPY_DEST;
        else if (step_q <= 4'(`NCS_ADDR_CYC)) begin
          cyc_d.kind = NCS_CYC_ADDR;
          cyc_d.data = faddr_q[8*(step_q-4'h1) +: 8];
        end else begin
          // program starts only on the confirm code
          cyc_d.data = `NCS_CMD_PROG_GO;
          cyc_last_d = 1'b1;
        end
      end
      `NCS_OP_DATA_IN: begin
        if (step_q == 4'h0) cyc_d.data = `NCS_CMD_COPY_DEST;
        else if (step_q <= 4'h2) begin
          cyc_d.kind = NCS_CYC_ADDR;
          cyc_d.data = faddr_q[8*(step_q-4'h1) +: 8];
        end else begin
          cyc_d.kind = NCS_CYC_WDATA;
          cyc_d.data = wbyte_q;
          cyc_last_d = 1'b1;
        end
      end
      `NCS_OP_ERASE: begin
        if (step_q == 4'h0) cyc_d.data = `NCS_CMD_ERASE_SETUP;
        else if (step_q <= 4'h2) begin
          // only address bytes 2 and 3, the first two of the three row bytes, which carry the block bits
          cyc_d.kind = NCS_CYC_ADDR;
          cyc_d.data = faddr_q[8*(step_q+4'h1) +: 8];
        end else begin
          cyc_d.data = `NCS_CMD_ERASE_GO;
          cyc_last_d = 1'b1;
        end
      end
      `NCS_OP_STATUS: begin
        if (step_q == 4'h0) cyc_d.data = `NCS_CMD_STATUS;
        else begin
          cyc_d.kind = NCS_CYC_RDATA;
          cyc_last_d = 1'b1;
        end
      end
      `NCS_OP_READ_ID: begin
        if (step_q == 4'h0) cyc_d.data = `NCS_CMD_READ_ID;
        else if (step_q == 4'h1) begin
          cyc_d.kind = NCS_CYC_ADDR;
          cyc_d.data = `NCS_ID_ADDR;
        end else begin
          cyc_d.kind = NCS_CYC_RDATA;
          cyc_last_d = (step_q == 4'h5);
        end
      end
      `NCS_OP_RESET: begin
        cyc_d.data = `NCS_CMD_RESET;
        cyc_last_d = 1'b1;
      end
      `NCS_OP_READ_BYTE: begin
        cyc_d.kind = NCS_CYC_RDATA;
        cyc_last_d = 1'b1;
      end
      default: cyc_last_d = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation sequencer
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q     <= ST_POWER;
      op_q        <= 4'h0;
      step_q      <= 4'h0;
      power_q     <= 14'h0;
      cyc_start_q <= 1'b0;
      cyc_q       <= '0;
      op_busy_q   <= 1'b0;
      dev_busy_q  <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      cyc_start_q <= 1'b0;
      if (wr_in && addr_in == `NCS_REG_STATUS && wdata_in[2]) begin
        done_q <= 1'b0;
      end
      case (state_q)
        ST_POWER: begin
          power_q <= power_q + 14'h1;
          if (power_q == 14'(POWER_WAIT_CYC - 1)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // busy left behind by program or erase clears once the line is back high
          if (dev_busy_q && rdy_q) begin
            dev_busy_q <= 1'b0;
          end
          if (wr_in && addr_in == `NCS_REG_CTRL) begin
            // while the device is busy only status and reset are sent
            if (!dev_busy_q || wdata_in[3:0] == `NCS_OP_STATUS ||
                wdata_in[3:0] == `NCS_OP_RESET) begin
              op_q      <= wdata_in[`NCS_CTRL_OP_LSB +: `NCS_CTRL_OP_W];
              step_q    <= 4'h0;
              op_busy_q <= 1'b1;
              state_q   <= ST_ISSUE;
            end
          end
        end
        ST_ISSUE: begin
          cyc_q       <= cyc_d;
          cyc_start_q <= 1'b1;
          state_q     <= ST_WAIT_CYC;
        end
        ST_WAIT_CYC: begin
          if (cyc_done) begin
            step_q <= step_q + 4'h1;
            if (!cyc_last_d) begin
              state_q <= ST_ISSUE;
            end else if (op_q == `NCS_OP_COPY_READ || op_q == `NCS_OP_RESET ||
                         is_prog_op(op_q)) begin
              state_q    <= ST_WAIT_BUSY;
              dev_busy_q <= 1'b1;
              power_q    <= 14'h0;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_WAIT_BUSY: begin
          // the ready line falls some time after the last write strobe
          power_q <= power_q + 14'h1;
          if (!rdy_q || power_q == 14'h00FF) begin
            // program and erase finish in the background so status stays reachable
            state_q <= is_prog_op(op_q) ? ST_DONE : ST_WAIT_READY;
          end
        end
        ST_WAIT_READY: begin
          if (rdy_q) begin
            dev_busy_q <= 1'b0;
            state_q    <= ST_DONE;
          end
        end
        ST_DONE: begin
          op_busy_q <= 1'b0;
          done_q    <= 1'b1;
          state_q   <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read results; status mode and id mode persist in the device until a new command
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rbyte_q    <= 8'h00;
      flash_st_q <= `NCS_ST_RESET_VAL;
      id_q       <= 32'h0;
      fail_q     <= 1'b0;
    end else if (cyc_done && cyc_q.kind == NCS_CYC_RDATA) begin
      rbyte_q <= cyc_rdata;
      if (op_q == `NCS_OP_STATUS) begin
        flash_st_q <= cyc_rdata;
        fail_q     <= cyc_rdata[`NCS_ST_FAIL] | cyc_rdata[`NCS_ST_PREV_FAIL];
      end
      if (op_q == `NCS_OP_READ_ID) begin
        id_q <= {cyc_rdata, id_q[31:8]};
      end
    end
  end

  ncs_bus_cycle u_cycle (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .start_in    (cyc_start_q),
    .cyc_in      (cyc_q),
    .done_out    (cyc_done),
    .rdata_out   (cyc_rdata),
    .cle_out     (cle),
    .ale_out     (ale),
    .we_n_out    (we_n),
    .re_n_out    (re_n),
    .io_out      (io_out),
    .io_oe_n_out (io_oe_n_out),
    .io_sync_in  (io_stable_q)
  );

  // chip select held low once out of the power wait; write protect follows software
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pins_out <= '{chip_sel_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0,
                    write_strobe_n: 1'b1, read_strobe_n: 1'b1, write_prot_n: 1'b0};
    end else begin
      pins_out.chip_sel_n     <= (state_q == ST_POWER);
      pins_out.cmd_latch      <= cle;
      pins_out.addr_latch     <= ale;
      pins_out.write_strobe_n <= we_n;
      pins_out.read_strobe_n  <= re_n;
      pins_out.write_prot_n   <= wp_off_q;
    end
  end

  a_power_wait_cs: assert property (@(posedge clock_in) disable iff (rst_in)
    (state_q == ST_POWER) |=> pins_out.chip_sel_n)
    else $error("chip select active during power wait");
  a_busy_only_status: assert property (@(posedge clock_in) disable iff (rst_in)
    (state_q == ST_IDLE && dev_busy_q && wr_in && addr_in == `NCS_REG_CTRL &&
     wdata_in[3:0] != `NCS_OP_STATUS && wdata_in[3:0] != `NCS_OP_RESET)
    |=> state_q == ST_IDLE)
    else $error("command issued while device busy");
  sequence s_release;
    !dev_busy_q ##1 done_q;
  endsequence
  a_ready_release: assert property (@(posedge clock_in) disable iff (rst_in)
    (state_q == ST_WAIT_READY && rdy_q) |=> s_release)
    else $error("busy not cleared on ready");
  a_prog_busy_flag: assert property (@(posedge clock_in) disable iff (rst_in)
    (state_q == ST_WAIT_CYC && cyc_done && cyc_last_d && is_prog_op(op_q))
    |=> dev_busy_q)
    else $error("device busy not flagged after program or erase");
  a_busy_clear: assert property (@(posedge clock_in) disable iff (rst_in)
    (state_q == ST_IDLE && dev_busy_q && rdy_q) |=> !dev_busy_q)
    else $error("device busy kept after ready");
  a_wp_pin_follow: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_in && addr_in == `NCS_REG_CTRL)
    |=> ##1 pins_out.write_prot_n == $past(wdata_in[31], 2))
    else $error("write protect pin does not follow control");
endmodule

// file: dv/ncs_flash_model.sv
// behavioural nand flash device on the far side of the host controller
`timescale 1ns/1ps
module ncs_flash_model
  import ncs_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h3A, // arbitrary value
  parameter logic [7:0] DEV_CODE   = 8'h5C, // arbitrary value
  parameter logic [7:0] ORG_CODE   = 8'h27, // arbitrary value
  parameter int         BUSY_NS    = 800
)(
  // pins from the controller
  input  wire ncs_pkg::ncs_pins_s pins_in,
  input  wire logic [7:0]        io_drv_in,
  input  wire logic              io_oe_n_in,
  // failure injection from the bench
  input  wire logic              fail_in,
  // resolved wires
  output logic [7:0]             io_bus_out,
  output logic                   ready_out
);
  logic [7:0] cmd_q = 8'h00, last_q = 8'h00, patch_q = 8'h00, rd_byte;
  logic [7:0] addr_q [5];
  logic [23:0] prog_row = 24'h0;
  logic [15:0] erased_row = 16'h0;
  logic busy = 1'b0, fail_q = 1'b0, after_rst = 1'b0, copy_ok = 1'b0;
  int n_addr = 0, mode = 0, idx = 0, n_erase = 0, n_prog = 0, n_id = 0;
  event go;
  logic [7:0] status;
  //////////////////////////////////////////////////////////////////////
  assign status = {pins_in.write_prot_n, ~busy, ~busy & ~after_rst, 4'h0, fail_q};
  assign rd_byte = (mode == 1) ? status :
                   (mode == 2) ? ((idx == 0) ? MAKER_CODE : (idx == 1) ? DEV_CODE :
                                  (idx == 2) ? 8'h00 : ORG_CODE) : patch_q;
  // a released bus shows the inverse of its last value, never a stale match
  assign io_bus_out = !io_oe_n_in ? io_drv_in :
                      (!pins_in.chip_sel_n && !pins_in.read_strobe_n) ? rd_byte : ~last_q;
  assign ready_out = ~busy;
  always @(go) begin
    busy = 1'b1;
    #(BUSY_NS);
    busy = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  always @(posedge pins_in.write_strobe_n) begin
    last_q = io_bus_out;
    if (!pins_in.chip_sel_n && pins_in.cmd_latch) begin
      if (!busy || io_bus_out == 8'h70 || io_bus_out == 8'hFF) begin
        case (io_bus_out)
          8'h70: mode = 1;
          8'h90: begin mode = 2; idx = 0; n_addr = 0; n_id++; end
          8'hFF: begin fail_q = 0; after_rst = 1; mode = 0; copy_ok = 0; -> go; end
          8'h00: begin mode = 0; n_addr = 0; end
          8'h35: begin copy_ok = 1; -> go; end
          8'h85: n_addr = 0;
          8'h60: n_addr = 0;
          8'h10: if (copy_ok && pins_in.write_prot_n) begin
            prog_row = {addr_q[4], addr_q[3], addr_q[2]};
            n_prog++;
            fail_q = fail_in;
            after_rst = 0;
            -> go;
          end
          8'hD0: if (cmd_q == 8'h60 && n_addr == 2 && pins_in.write_prot_n) begin
            erased_row = {addr_q[1], addr_q[0]};
            n_erase++;
            fail_q = 0;
            after_rst = 0;
            -> go;
          end
          default: ;
        endcase
        cmd_q = io_bus_out;
      end
    end else if (!pins_in.chip_sel_n && pins_in.addr_latch && !busy) begin
      if (n_addr < 5) addr_q[n_addr] = io_bus_out;
      n_addr++;
    end else if (!pins_in.chip_sel_n && cmd_q == 8'h85 && n_addr == 2) begin
      patch_q = io_bus_out;
    end
  end
  always @(posedge pins_in.read_strobe_n) begin
    if (!pins_in.chip_sel_n) begin
      last_q = io_bus_out;
      if (mode == 2) idx++;
    end
  end
endmodule

// file: dv/tb_ncs_host.sv
// self-checking bench for the nand host controller
`timescale 1ns/1ps
`include "ncs_defs.svh"
module tb_ncs_host;
  import ncs_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_in   = 1'b1;
  logic        wr_in    = 1'b0;
  logic        rd_in    = 1'b0;
  logic        fail_in  = 1'b0;
  logic [3:0]  addr_in  = 4'h0;
  logic [31:0] wdata_in = 32'h0;
  logic [31:0] rdata_out, got;
  ncs_pins_s   pins;
  logic [7:0]  io_drv, io_bus;
  logic        io_oe_n, ready;
  int          fails = 0, total_checks = 0, n_low = 0, mark, k;
  always #4 clock_in = ~clock_in;
  always @(negedge ready) n_low++;
  ncs_host #(.POWER_WAIT_CYC(20)) u_dut (
    .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pins_out(pins),
    .io_out(io_drv), .io_oe_n_out(io_oe_n), .io_in(io_bus), .ready_in(ready));
  ncs_flash_model u_flash (
    .pins_in(pins), .io_drv_in(io_drv), .io_oe_n_in(io_oe_n), .fail_in(fail_in),
    .io_bus_out(io_bus), .ready_out(ready));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in   <= 1'b0;
    #1 got = rdata_out;
  endtask
  // polls the op busy and device busy flags; a hang counts as a mismatch
  task automatic op(input logic [3:0] code, input logic wp_off);
    int i;
    i = 0;
    wr(`NCS_REG_CTRL, {wp_off, 27'h0, code});
    repeat (4) @(posedge clock_in);
    do begin
      rd(`NCS_REG_STATUS);
      i++;
    end while ((got[1] !== 1'b0 || got[4] !== 1'b0) && i < 2000);
    if (i >= 2000) fails++;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    #1 chk("rdata_rst", rdata_out, 32'h0);
    chk("wp_rst", 32'(pins.write_prot_n), 32'h0);
    rd(`NCS_REG_STATUS);
    chk("power_wait", 32'(got[0]), 32'h1);
    chk("cs_in_wait", 32'(pins.chip_sel_n), 32'h1);
    repeat (30) @(posedge clock_in);
    rd(`NCS_REG_STATUS);
    chk("power_done", 32'(got[0]), 32'h0);
    op(`NCS_OP_STATUS, 1'b1);
    rd(`NCS_REG_FLASH_ST);
    chk("status_idle", got, 32'hE0);
    op(`NCS_OP_STATUS, 1'b0);
    rd(`NCS_REG_FLASH_ST);
    chk("status_wp", got, 32'h60);
    op(`NCS_OP_READ_ID, 1'b1);
    rd(`NCS_REG_ID);
    chk("id_bytes", got, 32'h2700_5C3A);
    wr(`NCS_REG_ADDR_LO, 32'h5A3C_2211);
    mark = n_low;
    op(`NCS_OP_ERASE, 1'b1);
    chk("erase_row", 32'(u_flash.erased_row), 32'h5A3C);
    chk("erase_busy", 32'(n_low - mark), 32'h1);
    op(`NCS_OP_ERASE, 1'b0);
    chk("erase_wp", 32'(u_flash.n_erase), 32'h1);
    wr(`NCS_REG_ADDR_LO, 32'h7766_0000);
    wr(`NCS_REG_ADDR_HI, 32'h01);
    op(`NCS_OP_COPY_READ, 1'b1);
    wr(`NCS_REG_WDATA, 32'h9E);
    wr(`NCS_REG_ADDR_LO, 32'h0000_0034);
    op(`NCS_OP_DATA_IN, 1'b1);
    chk("patch_byte", 32'(u_flash.patch_q), 32'h9E);
    wr(`NCS_REG_ADDR_LO, 32'h4433_0000);
    wr(`NCS_REG_ADDR_HI, 32'h02);
    fail_in <= 1'b1;
    op(`NCS_OP_COPY_PROG, 1'b1);
    chk("prog_row", 32'(u_flash.prog_row), 32'h02_4433);
    op(`NCS_OP_STATUS, 1'b1);
    rd(`NCS_REG_FLASH_ST);
    chk("prog_fail_st", got, 32'hE1);
    rd(`NCS_REG_STATUS);
    chk("prog_fail_flag", 32'(got[3]), 32'h1);
    fail_in <= 1'b0;
    mark = n_low;
    op(`NCS_OP_RESET, 1'b1);
    chk("reset_busy", 32'(n_low - mark), 32'h1);
    op(`NCS_OP_STATUS, 1'b1);
    rd(`NCS_REG_FLASH_ST);
    chk("reset_status", got, 32'hC0);
    op(`NCS_OP_READ_BYTE, 1'b1);
    rd(`NCS_REG_RDATA);
    chk("status_hold", got, 32'hC0);
    mark = u_flash.n_id;
    wr(`NCS_REG_ADDR_LO, 32'h5A3C_2211);
    wr(`NCS_REG_CTRL, {1'b1, 27'h0, `NCS_OP_ERASE});
    repeat (4) @(posedge clock_in);
    k = 0;
    do begin
      rd(`NCS_REG_STATUS);
      k++;
    end while (got[1] !== 1'b0 && k < 2000);
    if (k >= 2000) fails++;
    chk("busy_flag", 32'(got[4]), 32'h1);
    op(`NCS_OP_READ_ID, 1'b1);
    chk("busy_refuse", 32'(u_flash.n_id - mark), 32'h0);
    chk("erase_again", 32'(u_flash.n_erase), 32'h2);
    finish_test();
  end
endmodule
